// ===== rpx_pkg.sv
// Package for the remappable pin crossbar: register map, select codes,
// reset values and carrier structs.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz aclk.
package rpx_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_PINS      = 8;
   localparam int OUT_SEL_W     = 6;
   localparam int IN_SEL_W      = 7;
   localparam int ADDR_W        = 8;
   localparam int PIN_IDX_W     = 3;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_OUT_MAP_BASE = 8'h00;
   localparam logic [7:0] OFS_SPI2_IN_SEL  = 8'h20;
   localparam logic [7:0] OFS_STATUS       = 8'h24;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int SPI2_DATA_SEL_LSB  = 0;
   localparam int SPI2_CLK_SEL_LSB   = 8;
   localparam logic [5:0]  OUT_SEL_RESET = 6'h00;
   localparam logic [15:0] IN_SEL_RESET  = 16'h0000;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ----------------------------------------------------------------
   // Output select codes
   // ----------------------------------------------------------------
   localparam logic [5:0] OSEL_DEFAULT   = 6'h00;
   localparam logic [5:0] OSEL_UART1_TX  = 6'h01;
   localparam logic [5:0] OSEL_UART2_TX  = 6'h03;
   localparam logic [5:0] OSEL_SPI2_SDO  = 6'h08;
   localparam logic [5:0] OSEL_SPI2_SCK  = 6'h09;
   localparam logic [5:0] OSEL_SPI2_SS   = 6'h0A;
   localparam logic [5:0] OSEL_CAN_TX    = 6'h0E;
   localparam logic [5:0] OSEL_OC1       = 6'h10;
   localparam logic [5:0] OSEL_OC2       = 6'h11;
   localparam logic [5:0] OSEL_OC3       = 6'h12;
   localparam logic [5:0] OSEL_OC4       = 6'h13;
   localparam logic [5:0] OSEL_CMP1      = 6'h18;
   localparam logic [5:0] OSEL_CMP2      = 6'h19;
   localparam logic [5:0] OSEL_CMP3      = 6'h1A;
   localparam logic [5:0] OSEL_PWM_SYNC  = 6'h2D;
   localparam logic [5:0] OSEL_QEI_CMP   = 6'h2F;
   localparam logic [5:0] OSEL_REFCLK    = 6'h31;
   localparam logic [5:0] OSEL_CMP4      = 6'h32;

   // ----------------------------------------------------------------
   // Input select codes
   // ----------------------------------------------------------------
   localparam logic [6:0] ISEL_GROUND    = 7'h00;
   localparam logic [6:0] ISEL_CMP1      = 7'h01;
   localparam logic [6:0] ISEL_PIN_BASE  = 7'h20;
   localparam logic [6:0] ISEL_MAX       = 7'h79;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic uart_one_transmit;
      logic uart_two_transmit;
      logic spi_two_serial_out;
      logic spi_two_clock_out;
      logic spi_two_slave_select;
      logic can_transmit_line;
      logic compare_channel_one_out;
      logic compare_channel_two_out;
      logic compare_channel_three_out;
      logic compare_channel_four_out;
      logic comparator_one_out;
      logic comparator_two_out;
      logic comparator_three_out;
      logic comparator_four_out;
      logic pwm_timebase_sync_out;
      logic encoder_counter_compare_out;
      logic reference_clock_out;
   } rpx_periph_out_t;

   typedef struct packed {
      logic spi2_clock_in;
      logic spi2_data_in;
   } rpx_periph_in_t;

endpackage : rpx_pkg

// ===== rpx_sel_mem.sv
// Small register array holding the per-pin output select fields.
// Assumes one write port and one registered read port on aclk.
`timescale 1ns/100ps
module rpx_sel_mem
   import rpx_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic                         ce,
   // Write port
   input  wire logic                         wr_en,
   input  wire logic [PIN_IDX_W-1:0]         wr_idx,
   input  wire logic [OUT_SEL_W-1:0]         wr_data,
   // Read port
   input  wire logic [PIN_IDX_W-1:0]         rd_idx,
   output      logic [OUT_SEL_W-1:0]         rd_data,
   // All fields for the crossbar
   output      logic [NUM_PINS*OUT_SEL_W-1:0] fields
);

   logic [OUT_SEL_W-1:0] mem [NUM_PINS];

   // ----------------------------------------------------------------
   // Storage; all fields zero so no pin is remapped after reset
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            mem[i] <= OUT_SEL_RESET;
         end
      end else if (ce && wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // Registered read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data <= OUT_SEL_RESET;
      end else if (ce) begin
         rd_data <= mem[rd_idx];
      end
   end

   // Flattened view of every field
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         fields[i*OUT_SEL_W +: OUT_SEL_W] = mem[i];
      end
   end

endmodule : rpx_sel_mem

// ===== rpx_crossbar.sv
// Remappable pin crossbar with AXI4-Lite register access.
// Assumes peripheral outputs and default port data are on aclk; pin
// inputs are asynchronous and are synchronised here.
//
// Functional notes
// - No interlocks between any mapping registers
// - Fan-out and fan-in mappings both allowed
// - Code zero selects default port function
// - Codes 01/03 route UART one/two transmit
// - Codes 08/09/0A route SPI two outputs
// - Code 0E routes CAN transmit, variant only
// - Codes 10..13 route compare channels one-four
// - Codes 18/19/1A route comparators one-three
// - Code 31 reference clock, 32 comparator four
// - Codes 2D/2F PWM sync, encoder compare (motor)
// - Per-pin six-bit field chooses driving output
// - All output selects zero after reset
`timescale 1ns/100ps
module rpx_crossbar
   import rpx_pkg::*;
#(
   parameter bit HAS_CAN   = 1'b1,
   parameter bit HAS_MOTOR = 1'b1
)(
   // Clock, reset, enable
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   // AXI4-Lite read data
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Peripheral side
   input  wire rpx_periph_out_t       periph_out,
   output      rpx_periph_in_t        periph_in,
   // Pin side
   input  wire logic [NUM_PINS-1:0]   port_default_out,
   input  wire logic [NUM_PINS-1:0]   remappable_pin_in,
   output      logic [NUM_PINS-1:0]   remappable_pin_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_EXEC = 3'b010,
      WR_RESP = 3'b100
   } rpx_wr_state_t;

   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_WAIT = 3'b010,
      RD_RESP = 3'b100
   } rpx_rd_state_t;

   rpx_wr_state_t              wr_state_reg;
   rpx_rd_state_t              rd_state_reg;
   logic                       aw_held_reg;
   logic                       w_held_reg;
   logic [ADDR_W-1:0]          awaddr_reg;
   logic [31:0]                wdata_reg;
   logic [3:0]                 wstrb_reg;
   logic [ADDR_W-1:0]          araddr_reg;
   logic [1:0]                 bresp_reg;
   logic [31:0]                rdata_reg;
   logic [1:0]                 rresp_reg;
   logic [15:0]                spi2_clock_data_input_select_reg;
   logic [NUM_PINS-1:0]        pin_s1_reg;
   logic [NUM_PINS-1:0]        pin_s2_reg;
   logic [NUM_PINS-1:0]        pin_s3_reg;
   logic [NUM_PINS-1:0]        pin_stable_reg;
   logic [NUM_PINS-1:0]        pin_out_reg;
   logic [NUM_PINS*OUT_SEL_W-1:0] out_fields;
   logic [OUT_SEL_W-1:0]       mem_rd_data;
   logic                       mem_wr_en;
   logic [PIN_IDX_W-1:0]       mem_wr_idx;
   logic [PIN_IDX_W-1:0]       mem_rd_idx;
   logic                       wr_is_map;
   logic                       rd_is_map;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Byte address falls inside the pin output map block
   function automatic logic is_map_addr(input logic [ADDR_W-1:0] a);
      is_map_addr = (a[ADDR_W-1:5] == OFS_OUT_MAP_BASE[ADDR_W-1:5]);
   endfunction : is_map_addr

   // Pin index from a byte address in the map block
   function automatic logic [PIN_IDX_W-1:0] map_idx(input logic [ADDR_W-1:0] a);
      map_idx = a[PIN_IDX_W+1:2];
   endfunction : map_idx

   // One output select code to the driving signal
   function automatic logic route_out(input logic [OUT_SEL_W-1:0] sel,
                                      input rpx_periph_out_t     p,
                                      input logic                dflt);
      unique case (sel)
         OSEL_UART1_TX : route_out = p.uart_one_transmit;
         OSEL_UART2_TX : route_out = p.uart_two_transmit;
         OSEL_SPI2_SDO : route_out = p.spi_two_serial_out;
         OSEL_SPI2_SCK : route_out = p.spi_two_clock_out;
         OSEL_SPI2_SS  : route_out = p.spi_two_slave_select;
         OSEL_CAN_TX   : route_out = HAS_CAN ? p.can_transmit_line : dflt;
         OSEL_OC1      : route_out = p.compare_channel_one_out;
         OSEL_OC2      : route_out = p.compare_channel_two_out;
         OSEL_OC3      : route_out = p.compare_channel_three_out;
         OSEL_OC4      : route_out = p.compare_channel_four_out;
         OSEL_CMP1     : route_out = p.comparator_one_out;
         OSEL_CMP2     : route_out = p.comparator_two_out;
         OSEL_CMP3     : route_out = p.comparator_three_out;
         OSEL_PWM_SYNC : route_out = HAS_MOTOR ? p.pwm_timebase_sync_out : dflt;
         OSEL_QEI_CMP  : route_out = HAS_MOTOR ? p.encoder_counter_compare_out : dflt;
         OSEL_REFCLK   : route_out = p.reference_clock_out;
         OSEL_CMP4     : route_out = p.comparator_four_out;
         default       : route_out = dflt;
      endcase
   endfunction : route_out

   // One input select code to the peripheral input value
   function automatic logic route_in(input logic [IN_SEL_W-1:0] sel,
                                     input logic [NUM_PINS-1:0] pins,
                                     input logic                cmp1);
      logic [IN_SEL_W-1:0] ofs;
      ofs = sel - ISEL_PIN_BASE;
      if (sel == ISEL_CMP1) begin
         route_in = cmp1;
      end else if (sel >= ISEL_PIN_BASE && sel <= ISEL_MAX && ofs < IN_SEL_W'(NUM_PINS)) begin
         route_in = pins[ofs[PIN_IDX_W-1:0]];
      end else begin
         route_in = 1'b0;
      end
   endfunction : route_in

   // ----------------------------------------------------------------
   // Output select storage
   // ----------------------------------------------------------------
   assign wr_is_map  = is_map_addr(awaddr_reg);
   assign rd_is_map  = is_map_addr(araddr_reg);
   assign mem_wr_en  = (wr_state_reg == WR_EXEC) && wr_is_map && wstrb_reg[0];
   assign mem_wr_idx = map_idx(awaddr_reg);
   assign mem_rd_idx = map_idx(s_axi_arready ? s_axi_araddr : araddr_reg); // Array read starts at accept

   rpx_sel_mem i_rpx_sel_mem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .wr_en   (mem_wr_en),
      .wr_idx  (mem_wr_idx),
      .wr_data (wdata_reg[OUT_SEL_W-1:0]),
      .rd_idx  (mem_rd_idx),
      .rd_data (mem_rd_data),
      .fields  (out_fields)
   );

   // ----------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------------------------------
   assign s_axi_awready = (wr_state_reg == WR_IDLE) && !aw_held_reg && ce;
   assign s_axi_wready  = (wr_state_reg == WR_IDLE) && !w_held_reg && ce;
   assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
   assign s_axi_bresp   = bresp_reg;

   // Capture of address and data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_state_reg == WR_EXEC) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
         end
      end
   end

   // Write sequencing and register update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= WR_IDLE;
         bresp_reg    <= RESP_OKAY;
         spi2_clock_data_input_select_reg <= IN_SEL_RESET;
      end else if (ce) begin
         unique case (wr_state_reg)
            WR_IDLE : begin
               if (aw_held_reg && w_held_reg) begin
                  wr_state_reg <= WR_EXEC;
               end
            end
            WR_EXEC : begin
               wr_state_reg <= WR_RESP;
               bresp_reg    <= RESP_OKAY;
               if (awaddr_reg == OFS_SPI2_IN_SEL) begin
                  // Bit 15 and bit 7 are unimplemented, kept zero
                  if (wstrb_reg[0]) begin
                     spi2_clock_data_input_select_reg[7:0] <= {1'b0, wdata_reg[6:0]};
                  end
                  if (wstrb_reg[1]) begin
                     spi2_clock_data_input_select_reg[15:8] <= {1'b0, wdata_reg[14:8]};
                  end
               end else if (!wr_is_map && awaddr_reg != OFS_STATUS) begin
                  bresp_reg <= RESP_SLVERR;
               end
            end
            WR_RESP : begin
               if (s_axi_bready) begin
                  wr_state_reg <= WR_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read channel: one cycle for the array read, then answer
   // ----------------------------------------------------------------
   assign s_axi_arready = (rd_state_reg == RD_IDLE) && ce;
   assign s_axi_rvalid  = (rd_state_reg == RD_RESP);
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= RD_IDLE;
         araddr_reg   <= '0;
         rdata_reg    <= 32'h00000000;
         rresp_reg    <= RESP_OKAY;
      end else if (ce) begin
         unique case (rd_state_reg)
            RD_IDLE : begin
               if (s_axi_arvalid) begin
                  araddr_reg   <= s_axi_araddr;
                  rd_state_reg <= RD_WAIT;
               end
            end
            RD_WAIT : begin
               rd_state_reg <= RD_RESP;
               rresp_reg    <= RESP_OKAY;
               if (rd_is_map) begin
                  rdata_reg <= {26'h0000000, mem_rd_data};
               end else if (araddr_reg == OFS_SPI2_IN_SEL) begin
                  rdata_reg <= {16'h0000, spi2_clock_data_input_select_reg};
               end else if (araddr_reg == OFS_STATUS) begin
                  // Live view of the synchronised pins and driven pins
                  rdata_reg <= {16'h0000, pin_out_reg, pin_stable_reg};
               end else begin
                  rdata_reg <= 32'h00000000;
                  rresp_reg <= RESP_SLVERR;
               end
            end
            RD_RESP : begin
               if (s_axi_rready) begin
                  rd_state_reg <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin input synchroniser; change accepted when stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_reg     <= '0;
         pin_s2_reg     <= '0;
         pin_s3_reg     <= '0;
         pin_stable_reg <= '0;
      end else if (ce) begin
         pin_s1_reg <= remappable_pin_in;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_stable_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Output crossbar; each pin decoded alone so any mix is legal
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_reg <= '0;
      end else if (ce) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pin_out_reg[i] <= route_out(out_fields[i*OUT_SEL_W +: OUT_SEL_W],
                                        periph_out, port_default_out[i]);
         end
      end
   end

   assign remappable_pin_out = pin_out_reg;

   // ----------------------------------------------------------------
   // Input crossbar; several inputs may share one pin
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_in <= '0;
      end else if (ce) begin
         periph_in.spi2_clock_in <= route_in(spi2_clock_data_input_select_reg[SPI2_CLK_SEL_LSB +: IN_SEL_W],
                                             pin_stable_reg, periph_out.comparator_one_out);
         periph_in.spi2_data_in  <= route_in(spi2_clock_data_input_select_reg[SPI2_DATA_SEL_LSB +: IN_SEL_W],
                                             pin_stable_reg, periph_out.comparator_one_out);
      end
   end

endmodule : rpx_crossbar

// ===== rpx_crossbar_props.sv
// Checker for the pin crossbar: bus answer timing and pin 0 routing.
// Assumes aw and w are offered together, wstrb full and ce high.
`timescale 1ns/100ps
module rpx_crossbar_props
   import rpx_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Pins and peripherals
   input wire rpx_periph_out_t periph_out,
   input wire logic [NUM_PINS-1:0] port_default_out,
   input wire logic [NUM_PINS-1:0] remappable_pin_out
);
   logic [5:0] sel0;
   logic [2:0] quiet;
   wire logic  wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Shadow of pin 0 field; quiet lets the write settle first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel0  <= OSEL_DEFAULT;
         quiet <= 3'h0;
      end else if (wr_take && s_axi_awaddr == OFS_OUT_MAP_BASE) begin
         sel0  <= s_axi_wdata[5:0];
         quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
         quiet <= quiet + 3'h1;
      end
   end
   property p_dflt; quiet == 3'h7 && sel0 == OSEL_DEFAULT |=> remappable_pin_out[0] == $past(port_default_out[0]); endproperty
   a_dflt: assert property (p_dflt) else $error("pin 0 lost default");
   property p_uart; quiet == 3'h7 && sel0 == OSEL_UART1_TX |=> remappable_pin_out[0] == $past(periph_out.uart_one_transmit); endproperty
   a_uart: assert property (p_uart) else $error("pin 0 not uart one");
   property p_unused; quiet == 3'h7 && (sel0 == 6'h02 || sel0 == 6'h3F) |=> remappable_pin_out[0] == $past(port_default_out[0]); endproperty
   a_unused: assert property (p_unused) else $error("unused code not default");
   property p_refclk; quiet == 3'h7 && sel0 == OSEL_REFCLK |=> remappable_pin_out[0] == $past(periph_out.reference_clock_out); endproperty
   a_refclk: assert property (p_refclk) else $error("pin 0 not refclk");
   property p_wlat; wr_take |=> !s_axi_bvalid ##[1:2] s_axi_bvalid; endproperty
   a_wlat: assert property (p_wlat) else $error("write answer late");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##[1:2] s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_wblk: assert property (p_wblk) else $error("write taken while busy");
   property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rblk: assert property (p_rblk) else $error("read taken while busy");
endmodule : rpx_crossbar_props
bind rpx_crossbar rpx_crossbar_props i_rpx_crossbar_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .periph_out, .port_default_out, .remappable_pin_out);

// ===== rpx_far_model.sv
// Peripheral and pin side model for the crossbar.
// Assumes the bench sets external pin levels through pin_lvl.
`timescale 1ns/100ps
module rpx_far_model
   import rpx_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Bench pin levels
   input wire logic [NUM_PINS-1:0] pin_lvl,
   // Toward the crossbar
   output rpx_periph_out_t periph_out,
   output logic [NUM_PINS-1:0] port_default_out,
   output logic [NUM_PINS-1:0] remappable_pin_in
);
   logic [16:0] pat = 17'h00000;
   // Johnson pattern, so no output sits still long enough to hide a bad route
   always_ff @(posedge aclk) pat <= {pat[15:0], ~pat[16]};
   assign periph_out        = rpx_periph_out_t'(pat);
   assign port_default_out  = pat[16:9] ^ 8'hA5;
   assign remappable_pin_in = pin_lvl;
endmodule : rpx_far_model

// ===== rpx_crossbar_tb.sv
// Testbench for the crossbar: register bus tasks and routing checks.
// Assumes the far model in rpx_far_model and the bound checker.
`timescale 1ns/100ps
module rpx_crossbar_tb
   import rpx_pkg::*;
;
   logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, port_default_out, remappable_pin_in, remappable_pin_out, lvl;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   rpx_periph_out_t periph_out;
   rpx_periph_in_t periph_in;
   int mismatches = 0, n_checks = 0, cyc = 0;
   // Code table and the struct bit each one routes (31 means default)
   logic [5:0] codes[21] = '{OSEL_DEFAULT, OSEL_UART1_TX, 6'h02, OSEL_UART2_TX, OSEL_SPI2_SDO, OSEL_SPI2_SCK,
      OSEL_SPI2_SS, OSEL_CAN_TX, OSEL_OC1, OSEL_OC2, OSEL_OC3, OSEL_OC4, OSEL_CMP1, OSEL_CMP2, OSEL_CMP3,
      OSEL_PWM_SYNC, OSEL_QEI_CMP, OSEL_REFCLK, OSEL_CMP4, 6'h3F, OSEL_DEFAULT};
   int pos[21] = '{31, 16, 31, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 2, 1, 0, 3, 31, 31};
   rpx_crossbar i_rpx_crossbar (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_out,
      .periph_in, .port_default_out, .remappable_pin_in, .remappable_pin_out);
   rpx_far_model i_rpx_far_model (.aclk, .pin_lvl(lvl), .periph_out, .port_default_out, .remappable_pin_in);
   // Clock, 100 MHz
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Hang guard, far above the fewer than one thousand cycles needed
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Write: aw and w together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, b;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (b !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ar, rv;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         {ar, rv} = {s_axi_arready, s_axi_rvalid};
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (rv !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, r);
   endtask : rd
   // Pin p carrying table entry k, every cycle for 18
   task automatic pin_chk(input int p, input int k);
      logic e;
      logic [16:0] pv;
      @(posedge aclk);
      repeat (18) begin
         #1 pv = periph_out;
         e = (pos[k] == 31) ? port_default_out[p] : pv[pos[k]];
         @(posedge aclk);
         #1 chk(remappable_pin_out[p], e);
      end
   endtask : pin_chk
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
      rd(8'h28, 32'h0, RESP_SLVERR);
      wr(8'h28, 32'h1, RESP_SLVERR);
      wr(OFS_STATUS, 32'hFFFF, RESP_OKAY);
      for (int k = 0; k < 21; k++) begin
         wr(OFS_OUT_MAP_BASE, 32'(codes[k]), RESP_OKAY);
         pin_chk(0, k);
      end
      // Separate fields per pin, one code on two pins
      for (int p = 1; p < 8; p++) wr(8'(4 * p), 32'(codes[p + 8]), RESP_OKAY);
      wr(8'h1C, 32'(OSEL_OC2), RESP_OKAY);
      for (int p = 1; p < 8; p++) pin_chk(p, (p == 7) ? 9 : p + 8);
      rd(8'h1C, 32'(OSEL_OC2), RESP_OKAY);
      // Input selectors: pin 3 to clock, ground then pin 3 to data
      lvl <= 8'h08;
      wr(OFS_SPI2_IN_SEL, 32'h2300, RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk(periph_in, 2'b10);
      wr(OFS_SPI2_IN_SEL, 32'h2323, RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk(periph_in, 2'b11);
      lvl <= 8'h00;
      repeat (8) @(posedge aclk);
      chk(periph_in, 2'b00);
      rd(OFS_SPI2_IN_SEL, 32'h2323, RESP_OKAY);
      results();
   end
endmodule : rpx_crossbar_tb
